/* logic/sftg_pkg.sv */
package sftg_pkg;

  // ----------------------------------------
  // Clocking and settling times
  // ----------------------------------------
  localparam int unsigned CORE_CLK_HZ = 10_000_000;
  localparam int unsigned SETTLE_MAX_US = 1000;
  localparam int unsigned CFG_MAX_MS = 300;
  // Longest times, so the cycle counts round down
  localparam int unsigned SETTLE_CYCLES =
    SETTLE_MAX_US * (CORE_CLK_HZ / 1_000_000);
  localparam int unsigned CFG_CYCLES = CFG_MAX_MS * (CORE_CLK_HZ / 1000);
  localparam int unsigned PIN_SYNC_STAGES = 3;
  localparam int unsigned CDC_SYNC_STAGES = 2;

  // ----------------------------------------
  // Output formats and configuration word
  // ----------------------------------------
  localparam logic [2:0] FMT_FULL = 3'h0;
  localparam logic [2:0] FMT_MP13 = 3'h1;
  localparam logic [2:0] FMT_TV = 3'h2;
  localparam logic [2:0] FMT_QUARTER = 3'h3;
  localparam logic [2:0] FMT_EIGHTH = 3'h4;
  localparam int unsigned CFG_FMT_LSB = 2;
  localparam int unsigned CFG_SCALE_BIT = 1;
  localparam int unsigned CFG_SNAP_BIT = 0;
  localparam logic [4:0] CFG_RESET = 5'h00;
  localparam logic [11:0] SNAP_LINE_PERIOD = 12'hcb4; // 3252 pixels
  localparam logic [9:0] PIXEL_BLANK = 10'h000;

  // Line and frame geometry, counted in output pixels and lines
  typedef struct packed {
    logic [11:0] h_active;
    logic [11:0] hb_lead;
    logic [11:0] hb_trail;
    logic [10:0] v_active;
    logic [2:0] vsync_lines;
    logic [4:0] vb_lead;
    logic [4:0] vb_trail;
    logic [2:0] pclk_div; // Link cycles per pixel clock half period
  } geom_s;

  // 2592 x 1944, blank 192 + 468, 4 sync + 20 lines
  localparam geom_s GEOM_FULL = '{12'ha20, 12'hc0, 12'h1d4, 11'h798,
                                  3'h4, 5'h14, 5'h00, 3'h1};
  // 1280 x 960, blank 192 + 168, 4 sync + 13 lines
  localparam geom_s GEOM_MP13 = '{12'h500, 12'hc0, 12'ha8, 11'h3c0,
                                  3'h4, 5'h0d, 5'h00, 3'h1};
  // 864 x 600, blank 192 + 244
  localparam geom_s GEOM_TV = '{12'h360, 12'hc0, 12'hf4, 11'h258,
                                3'h4, 5'h0d, 5'h00, 3'h1};
  // 1280 x 480, blank 192 + 140
  localparam geom_s GEOM_QUARTER = '{12'h500, 12'hc0, 12'h8c, 11'h1e0,
                                     3'h4, 5'h0d, 5'h00, 3'h1};
  // 1280 x 240, blank 192 + 88
  localparam geom_s GEOM_EIGHTH = '{12'h500, 12'hc0, 12'h58, 11'h0f0,
                                    3'h4, 5'h0d, 5'h00, 3'h1};
  // Quarter format skipped 2:1, pixel clock halved
  localparam geom_s GEOM_VGA = '{12'h280, 12'h60, 12'h46, 11'h1e0,
                                 3'h4, 5'h0d, 5'h00, 3'h2};
  // Eighth format skipped 4:1, pixel clock quartered
  localparam geom_s GEOM_QVGA = '{12'h140, 12'h30, 12'h16, 11'h0f0,
                                  3'h4, 5'h0d, 5'h00, 3'h4};

  // Geometry of a format; unknown codes fall back to full size
  function automatic geom_s format_geometry(input logic [2:0] fmt,
                                            input logic scale);
    geom_s g;
    g = GEOM_FULL;
    case (fmt)
      FMT_MP13: g = GEOM_MP13;
      FMT_TV: g = GEOM_TV;
      FMT_QUARTER: g = scale ? GEOM_VGA : GEOM_QUARTER;
      FMT_EIGHTH: g = scale ? GEOM_QVGA : GEOM_EIGHTH;
      default: g = GEOM_FULL;
    endcase
    return g;
  endfunction : format_geometry

  // Link state machine
  typedef enum logic [1:0] {
    st_run = 2'b01,
    st_expose = 2'b10
  } link_state_e;

endpackage : sftg_pkg

/* logic/sync_chain.sv */
`timescale 1ns/100ps

module sync_chain #(
  parameter int unsigned STAGES = 3
) (
  // Destination clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Asynchronous level in
  input wire logic d,
  // Synchronised level and the stage before it
  output logic q,
  output logic q_early
);

  typedef struct packed {
    logic [STAGES-1:0] stages;
  } sync_s;

  sync_s sync_r;
  sync_s sync_next;

  // Shift towards the last stage; only later stages are read outside
  always_comb begin
    sync_next = sync_r;
    sync_next.stages = {sync_r.stages[STAGES-2:0], d};
  end

  // Registers clear to zero under reset
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sync_r <= '0;
    end else begin
      sync_r <= sync_next;
    end
  end

  assign q = sync_r.stages[STAGES-1];
  assign q_early = sync_r.stages[STAGES-2];

endmodule : sync_chain

/* logic/sensor_frame_timing_generator.sv */
`timescale 1ns/100ps


module sensor_frame_timing_generator #(
  parameter int unsigned SETTLE_CYCLES = sftg_pkg::SETTLE_CYCLES,
  parameter int unsigned CFG_CYCLES = sftg_pkg::CFG_CYCLES
) (
  // Control clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // Link clock, internal system clock of the pixel timing
  input wire logic sys_clk,
  // Configuration, core_clk domain
  input wire logic [2:0] format_select,
  input wire logic scale_output,
  input wire logic snapshot_enable,
  input wire logic cfg_load,
  output logic cfg_busy,
  output logic timing_ready,
  // Exposure request pin
  input wire logic external_exposure_request,
  // Sensor output pins, sys_clk domain
  output logic pclk,
  output logic line_valid,
  output logic frame_sync,
  output logic [9:0] pixel_data,
  output logic exposure_strobe
);

  // ----------------------------------------
  // Core domain state
  // ----------------------------------------
  typedef struct packed {
    logic [4:0] cfg;
    logic req_tog;
  } core_s;

  core_s core_r;
  core_s core_next;
  logic ack_core;
  logic alive_core;

  // Word held stable while a toggle is outstanding
  always_comb begin
    core_next = core_r;
    if (cfg_load && !cfg_busy) begin
      core_next.cfg = {format_select, scale_output, snapshot_enable};
      core_next.req_tog = ~core_r.req_tog;
    end
  end

  // Core registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      core_r <= '{cfg: sftg_pkg::CFG_RESET, req_tog: 1'b0};
    end else begin
      core_r <= core_next;
    end
  end

  // Busy until the link domain hands the toggle back
  assign cfg_busy = core_r.req_tog != ack_core;
  assign timing_ready = alive_core;

  // ----------------------------------------
  // Domain crossings
  // ----------------------------------------
  logic req_link;
  logic ack_tog_link;
  logic alive_link;
  logic exp_mid;
  logic exp_late;

  sync_chain #(.STAGES(sftg_pkg::CDC_SYNC_STAGES)) u_req_sync (
    .clk(sys_clk), .rstn(rstn), .d(core_r.req_tog),
    .q(req_link), .q_early()
  );
  sync_chain #(.STAGES(sftg_pkg::CDC_SYNC_STAGES)) u_ack_sync (
    .clk(core_clk), .rstn(rstn), .d(ack_tog_link),
    .q(ack_core), .q_early()
  );
  sync_chain #(.STAGES(sftg_pkg::CDC_SYNC_STAGES)) u_alive_sync (
    .clk(core_clk), .rstn(rstn), .d(alive_link),
    .q(alive_core), .q_early()
  );
  // Pin input: a change counts once the last two stages agree
  sync_chain #(.STAGES(sftg_pkg::PIN_SYNC_STAGES)) u_exp_sync (
    .clk(sys_clk), .rstn(rstn), .d(external_exposure_request),
    .q(exp_late), .q_early(exp_mid)
  );

  // ----------------------------------------
  // Link domain state
  // ----------------------------------------
  typedef struct packed {
    sftg_pkg::link_state_e state;
    logic [4:0] cfg;
    logic [4:0] cfg_pending;
    logic pending;
    logic req_seen;
    logic ack_tog;
    logic alive;
    logic exp_level;
    logic [2:0] div_cnt;
    logic pclk;
    logic [11:0] h_cnt;
    logic [10:0] v_cnt;
    logic line_valid;
    logic frame_sync;
    logic [9:0] pixel_data;
    logic strobe;
  } link_s;

  localparam link_s LINK_RESET = '{
    state: sftg_pkg::st_run, cfg: sftg_pkg::CFG_RESET,
    cfg_pending: sftg_pkg::CFG_RESET, pending: 1'b0, req_seen: 1'b0,
    ack_tog: 1'b0, alive: 1'b0, exp_level: 1'b0, div_cnt: 3'h0,
    pclk: 1'b0, h_cnt: 12'h000, v_cnt: 11'h000, line_valid: 1'b0,
    frame_sync: 1'b1, pixel_data: sftg_pkg::PIXEL_BLANK, strobe: 1'b0
  };

  link_s link_r;
  link_s link_next;

  // Back to the first sync line; used for new settings and after exposure
  function automatic link_s restart_frame(input link_s s);
    link_s o;
    o = s;
    o.state = sftg_pkg::st_run;
    o.h_cnt = 12'h000;
    o.v_cnt = 11'h000;
    o.line_valid = 1'b0;
    o.frame_sync = 1'b1;
    o.pixel_data = sftg_pkg::PIXEL_BLANK;
    o.strobe = 1'b0;
    return o;
  endfunction : restart_frame

  // Geometry of the running format and derived totals
  sftg_pkg::geom_s geo;
  logic [11:0] h_total;
  logic [10:0] v_total;
  logic [10:0] v_first_active;
  logic [11:0] h_next;
  logic [10:0] v_next;
  logic fall_tick;
  logic next_valid;
  assign geo = sftg_pkg::format_geometry(
    link_r.cfg[sftg_pkg::CFG_FMT_LSB +: 3],
    link_r.cfg[sftg_pkg::CFG_SCALE_BIT]);
  assign h_total = 12'(geo.hb_lead + geo.h_active + geo.hb_trail);
  assign v_first_active = 11'(11'(geo.vsync_lines) + 11'(geo.vb_lead));
  assign v_total = 11'(v_first_active + geo.v_active
                       + 11'(geo.vb_trail));
  assign h_next = (link_r.h_cnt == h_total - 12'h001) ? 12'h000
                : 12'(link_r.h_cnt + 12'h001);
  assign v_next = (link_r.h_cnt != h_total - 12'h001) ? link_r.v_cnt
                : (link_r.v_cnt == v_total - 11'h001) ? 11'h000
                : 11'(link_r.v_cnt + 11'h001);
  // Pixel clock falls in this cycle; every pin update waits for it
  assign fall_tick = link_r.pclk
                   && (link_r.div_cnt == geo.pclk_div - 3'h1);
  // Active window: after leading blanking, outside blank lines
  assign next_valid = (h_next >= geo.hb_lead)
                   && (h_next < 12'(geo.hb_lead + geo.h_active))
                   && (v_next >= v_first_active)
                   && (v_next < 11'(v_first_active + geo.v_active));

  // Next state of the pixel timing
  always_comb begin
    link_next = link_r;
    link_next.alive = 1'b1;
    if (exp_mid == exp_late) begin
      link_next.exp_level = exp_late;
    end
    // New settings are taken at once and applied at the next falling edge
    if (req_link != link_r.req_seen) begin
      link_next.req_seen = req_link;
      link_next.cfg_pending = core_r.cfg;
      link_next.pending = 1'b1;
    end
    // Pixel clock divider runs in both states
    if (link_r.div_cnt == geo.pclk_div - 3'h1) begin
      link_next.div_cnt = 3'h0;
      link_next.pclk = ~link_r.pclk;
    end else begin
      link_next.div_cnt = 3'(link_r.div_cnt + 3'h1);
    end
    if (fall_tick) begin
      if (link_r.pending) begin
        link_next = restart_frame(link_next);
        link_next.cfg = link_r.cfg_pending;
        link_next.pending = (req_link != link_r.req_seen);
        link_next.ack_tog = link_r.req_seen;
      end else begin
        case (link_r.state)
          sftg_pkg::st_run: begin
            if (link_r.cfg[sftg_pkg::CFG_SNAP_BIT] && link_r.exp_level) begin
              // Exposure: pins blank, strobe marks the exposure
              link_next.state = sftg_pkg::st_expose;
              link_next.strobe = 1'b1;
              link_next.line_valid = 1'b0;
              link_next.frame_sync = 1'b0;
              link_next.pixel_data = sftg_pkg::PIXEL_BLANK;
            end else begin
              link_next.h_cnt = h_next;
              link_next.v_cnt = v_next;
              link_next.line_valid = next_valid;
              link_next.frame_sync =
                v_next < 11'(geo.vsync_lines);
              // Test ramp stands in for array data, bit 9 on top
              link_next.pixel_data = next_valid
                ? {v_next[4:0], h_next[4:0]}
                : sftg_pkg::PIXEL_BLANK;
            end
          end
          sftg_pkg::st_expose: begin
            // Release of the request starts the readout frame
            if (!link_r.exp_level) begin
              link_next = restart_frame(link_next);
            end
          end
          default: begin
            link_next = restart_frame(link_next);
          end
        endcase
      end
    end
  end

  // Link registers
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      link_r <= LINK_RESET;
    end else begin
      link_r <= link_next;
    end
  end

  // ----------------------------------------
  // Output pins
  // ----------------------------------------
  assign ack_tog_link = link_r.ack_tog;
  assign alive_link = link_r.alive;
  assign pclk = link_r.pclk;
  assign line_valid = link_r.line_valid;
  assign frame_sync = link_r.frame_sync;
  assign pixel_data = link_r.pixel_data;
  assign exposure_strobe = link_r.strobe;

  // ----------------------------------------
  // Checks, link domain
  // ----------------------------------------
  // Helper: run lengths of line valid, in pixel periods
  logic prev_pclk;
  logic prev_lv;
  logic [11:0] run_cnt;
  logic [11:0] hi_len;
  logic [10:0] v_at_fall;
  logic [2:0] hp_cnt;
  logic pix_fall;
  assign pix_fall = prev_pclk && !link_r.pclk;
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      prev_pclk <= 1'b0;
      prev_lv <= 1'b0;
      run_cnt <= 12'h000;
      hi_len <= 12'h000;
      v_at_fall <= 11'h000;
      hp_cnt <= 3'h0;
    end else begin
      prev_pclk <= link_r.pclk;
      hp_cnt <= link_r.pclk ? 3'(hp_cnt + 3'h1) : 3'h0;
      if (pix_fall) begin
        prev_lv <= link_r.line_valid;
        run_cnt <= (link_r.line_valid != prev_lv) ? 12'h001
                 : 12'(run_cnt + 12'h001);
        if (prev_lv && !link_r.line_valid) begin
          hi_len <= run_cnt;
          v_at_fall <= link_r.v_cnt;
        end
      end
      // Frame start forgets the last fall, so no pairing across frames
      if (link_r.frame_sync) begin
        v_at_fall <= 11'h7fe;
      end
    end
  end

  property p_pins_on_fall;
    @(posedge sys_clk) disable iff (!rstn)
    ($changed(line_valid) || $changed(pixel_data) || $changed(frame_sync))
      |-> $fell(pclk);
  endproperty
  a_pins_on_fall: assert property (p_pins_on_fall)
    else $error("pin changed without a pixel clock fall");

  property p_data_only_valid;
    @(posedge sys_clk) disable iff (!rstn)
    !line_valid |-> pixel_data == sftg_pkg::PIXEL_BLANK;
  endproperty
  a_data_only_valid: assert property (p_data_only_valid)
    else $error("pixel data present outside line valid");

  property p_blank_lines;
    @(posedge sys_clk) disable iff (!rstn)
    (frame_sync || (link_r.v_cnt < v_first_active)
     || (link_r.v_cnt >= 11'(v_first_active + geo.v_active)))
      |-> !line_valid;
  endproperty
  a_blank_lines: assert property (p_blank_lines)
    else $error("line valid during vertical blanking");

  property p_sync_width;
    @(posedge sys_clk) disable iff (!rstn)
    ($fell(frame_sync) && $stable(link_r.cfg) && !exposure_strobe)
      |-> link_r.v_cnt == 11'(geo.vsync_lines) && link_r.h_cnt == 12'h000;
  endproperty
  a_sync_width: assert property (p_sync_width)
    else $error("frame sync width wrong");

  property p_active_width;
    @(posedge sys_clk) disable iff (!rstn)
    ($fell(line_valid) && $stable(link_r.cfg) && !exposure_strobe)
      |-> run_cnt == geo.h_active;
  endproperty
  a_active_width: assert property (p_active_width)
    else $error("active line width wrong");

  property p_hblank;
    @(posedge sys_clk) disable iff (!rstn)
    ($rose(line_valid) && $stable(link_r.cfg)
     && link_r.v_cnt == 11'(v_at_fall + 11'h001))
      |-> run_cnt == 12'(geo.hb_lead + geo.hb_trail)
          && 12'(run_cnt + hi_len) == h_total;
  endproperty
  a_hblank: assert property (p_hblank)
    else $error("horizontal blanking or line period wrong");

  property p_snap_line;
    @(posedge sys_clk) disable iff (!rstn)
    ($rose(line_valid) && $stable(link_r.cfg)
     && link_r.cfg[sftg_pkg::CFG_SNAP_BIT]
     && link_r.cfg[sftg_pkg::CFG_FMT_LSB +: 3] == sftg_pkg::FMT_FULL
     && link_r.v_cnt == 11'(v_at_fall + 11'h001))
      |-> 12'(run_cnt + hi_len) == sftg_pkg::SNAP_LINE_PERIOD;
  endproperty
  a_snap_line: assert property (p_snap_line)
    else $error("snapshot line period is not 3252");

  property p_pclk_half;
    @(posedge sys_clk) disable iff (!rstn)
    ($fell(pclk) && $stable(link_r.cfg)) |-> hp_cnt == geo.pclk_div;
  endproperty
  a_pclk_half: assert property (p_pclk_half)
    else $error("pixel clock high phase wrong");

  property p_expose_release;
    @(posedge sys_clk) disable iff (!rstn)
    $fell(exposure_strobe) |-> frame_sync && !line_valid
                               && link_r.v_cnt == 11'h000;
  endproperty
  a_expose_release: assert property (p_expose_release)
    else $error("exposure release did not start a frame");

  // ----------------------------------------
  // Checks, core domain
  // ----------------------------------------
  // Helper: cycles spent busy and cycles since reset until ready
  logic [21:0] busy_cnt;
  logic [21:0] boot_cnt;
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      busy_cnt <= 22'h000000;
      boot_cnt <= 22'h000000;
    end else begin
      busy_cnt <= cfg_busy ? 22'(busy_cnt + 22'h000001) : 22'h000000;
      if (!timing_ready) begin
        boot_cnt <= 22'(boot_cnt + 22'h000001);
      end
    end
  end

  property p_reset_settle;
    @(posedge core_clk) disable iff (!rstn)
    boot_cnt < SETTLE_CYCLES;
  endproperty
  a_reset_settle: assert property (p_reset_settle)
    else $error("timing not ready within settling time");

  property p_format_settle;
    @(posedge core_clk) disable iff (!rstn)
    busy_cnt < SETTLE_CYCLES;
  endproperty
  a_format_settle: assert property (p_format_settle)
    else $error("format change not applied within settling time");

  property p_cfg_settle;
    @(posedge core_clk) disable iff (!rstn)
    $rose(cfg_busy) |-> ##[1:1000] !cfg_busy;
  endproperty
  a_cfg_settle: assert property (p_cfg_settle)
    else $error("configuration not applied in time");

endmodule : sensor_frame_timing_generator

/* tb/capture_host.sv */
`timescale 1ns/100ps

// ----
// Capture port model
// ----
module capture_host #(
  parameter int SHUT_AT = 100
) (
  // Pixel link
  input wire logic pclk,
  input wire logic line_valid,
  input wire logic frame_sync,
  input wire logic [9:0] pixel_data,
  // Measurements
  output int line_period,
  output int active_len,
  output int sync_len,
  output int gap_len,
  output int n_lines,
  output int n_bad,
  output logic shutter_closed
);
  logic lv_q = 1'b0;
  logic fs_q = 1'b0;
  logic first = 1'b0;
  logic [4:0] last_lsb = 5'h00;
  int per = 0;
  int run = 0;
  int sc = 0;
  int gap = 0;
  int since = 0;

  // Counters start clear; no reset pin on the host side
  initial begin
    n_lines = 0;
    n_bad = 0;
    shutter_closed = 1'b0;
  end

  // Sample on the rising edge, where the sensor holds still
  always @(posedge pclk) begin
    per <= per + 1;
    if (line_valid && !lv_q) begin
      line_period <= per;
      per <= 1;
      if (first) gap_len <= gap;
      n_lines <= n_lines + 1;
    end
    run <= line_valid ? run + 1 : 0;
    if (!line_valid && lv_q) active_len <= run;
    sc <= frame_sync ? sc + 1 : 0;
    if (!frame_sync && fs_q) sync_len <= sc;
    gap <= frame_sync ? 0 : gap + 1;
    // Blanking must carry no data
    if (!line_valid && pixel_data !== 10'h000) n_bad <= n_bad + 1;
    if (line_valid && frame_sync) n_bad <= n_bad + 1;
    // Ramp steps once per pixel, bit 9 on top
    if (line_valid && lv_q && pixel_data[4:0] !== last_lsb + 5'h01)
      n_bad <= n_bad + 1;
    last_lsb <= pixel_data[4:0];
    // Shutter shut well inside the allowed window
    since <= (!frame_sync && fs_q) ? 0 : since + 1;
    if (since == SHUT_AT) shutter_closed <= 1'b1;
    // Gap is only meaningful for the first line of a frame
    first <= frame_sync | (first & ~(line_valid & ~lv_q));
    lv_q <= line_valid;
    fs_q <= frame_sync;
  end
endmodule : capture_host

/* tb/sensor_frame_timing_generator_test.sv */
`timescale 1ns/100ps

// ----
// Bench
// ----
module sensor_frame_timing_generator_test;
  logic core_clk = 1'b0;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  logic [2:0] format_select = 3'h0;
  logic scale_output = 1'b0;
  logic snapshot_enable = 1'b0;
  logic cfg_load = 1'b0;
  logic external_exposure_request = 1'b0;
  logic cfg_busy, timing_ready, pclk, line_valid, frame_sync;
  logic exposure_strobe;
  logic shutter_closed;
  logic [9:0] pixel_data;
  logic pclk_q = 1'b0;
  logic lv_q = 1'b0;
  int line_period, active_len, sync_len, gap_len, n_lines, n_bad;
  int failures = 0;
  int n_checks = 0;
  int half_run = 0;
  int half_seen = 0;
  integer seed = 32'h271d171f;
  int order[$];
  // Model: lead, active, trail, blank lines, pclk half period, format
  int hl[7] = '{192, 192, 192, 192, 192, 96, 48};
  int ha[7] = '{2592, 1280, 864, 1280, 1280, 640, 320};
  int ht[7] = '{468, 168, 244, 140, 88, 70, 22};
  int vb[7] = '{20, 13, 13, 13, 13, 13, 13};
  int hp[7] = '{1, 1, 1, 1, 1, 2, 4};
  logic [2:0] fc[7] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h3, 3'h4};

  always #50 core_clk = ~core_clk;
  always #3 sys_clk = ~sys_clk;

  sensor_frame_timing_generator #(.SETTLE_CYCLES(200), .CFG_CYCLES(400)) dut (
    .core_clk(core_clk), .rstn(rstn), .sys_clk(sys_clk),
    .format_select(format_select), .scale_output(scale_output),
    .snapshot_enable(snapshot_enable), .cfg_load(cfg_load),
    .cfg_busy(cfg_busy), .timing_ready(timing_ready),
    .external_exposure_request(external_exposure_request), .pclk(pclk),
    .line_valid(line_valid), .frame_sync(frame_sync),
    .pixel_data(pixel_data), .exposure_strobe(exposure_strobe));

  capture_host host (
    .pclk(pclk), .line_valid(line_valid), .frame_sync(frame_sync),
    .pixel_data(pixel_data), .line_period(line_period),
    .active_len(active_len), .sync_len(sync_len), .gap_len(gap_len),
    .n_lines(n_lines), .n_bad(n_bad), .shutter_closed(shutter_closed));

  task automatic report_and_stop();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
    n_checks++;
    if (exp !== got) begin
      failures++;
      $display("ERROR %s expected %0d seen %0d", what, exp, got);
    end
  endtask : check

  // Bounded wait on a level; a timeout ends the run
  task automatic wait_for(input string what, ref logic sig, input logic lvl,
                          input int bound);
    for (int i = 0; i < bound && sig !== lvl; i++) @(negedge core_clk);
    check(what, lvl, sig);
    if (sig !== lvl) report_and_stop();
  endtask : wait_for

  task automatic wait_lines(input int k);
    int base;
    base = n_lines;
    for (int i = 0; i < 30000 && n_lines < base + k; i++) @(negedge core_clk);
    check("line count", 1, n_lines >= base + k);
    if (n_lines < base + k) report_and_stop();
  endtask : wait_lines

  task automatic measure(input int k);
    int t;
    t = hl[k] + ha[k] + ht[k];
    check("line period", t, line_period);
    check("active pixels", ha[k], active_len);
    check("sync pixels", 4 * t, sync_len);
    check("blank gap", vb[k] * t + hl[k], gap_len);
    check("pclk half", hp[k], half_seen);
  endtask : measure

  task automatic run_setting(input int k, input logic snap);
    // Load outside sync, so a restart cannot stretch the sync pulse
    wait_for("sync low", frame_sync, 1'b0, 2000);
    @(negedge core_clk);
    format_select = fc[k];
    scale_output = (k > 4);
    snapshot_enable = snap;
    cfg_load = 1'b1;
    @(negedge core_clk);
    cfg_load = 1'b0;
    check("cfg_busy", 1, cfg_busy);
    wait_for("cfg_busy", cfg_busy, 1'b0, 400);
    wait_lines(3);
    measure(k);
  endtask : run_setting

  task automatic do_reset();
    rstn = 1'b0;
    repeat (5) @(negedge core_clk);
    check("reset frame_sync", 1, frame_sync);
    check("reset line_valid", 0, line_valid);
    rstn = 1'b1;
    wait_for("timing_ready", timing_ready, 1'b1, 200);
  endtask : do_reset

  // Edges of valid only where pclk has just fallen
  always @(negedge sys_clk) begin
    if (rstn && line_valid !== lv_q)
      check("valid edge", 1, pclk_q & ~pclk);
    if (pclk !== pclk_q) begin
      half_seen <= half_run;
      half_run <= 1;
    end else half_run <= half_run + 1;
    pclk_q <= pclk;
    lv_q <= line_valid;
  end

  initial begin
    int r;
    do_reset();
    r = $unsigned($random(seed)) % 7;
    for (int i = 0; i < 7; i++) order.push_back((i + r) % 7);
    foreach (order[j]) run_setting(order[j], 1'b0);
    run_setting(0, 1'b1);
    repeat ($unsigned($random(seed)) % 8 + 2) @(negedge core_clk);
    external_exposure_request = 1'b1;
    wait_for("strobe on", exposure_strobe, 1'b1, 20);
    // Held long, so every row finishes its reset
    repeat (60) begin
      @(negedge core_clk);
      check("exposure valid", 0, line_valid);
    end
    external_exposure_request = 1'b0;
    wait_for("strobe off", exposure_strobe, 1'b0, 20);
    wait_lines(3);
    measure(0);
    check("shutter closed", 1, shutter_closed);
    do_reset();
    run_setting(1, 1'b0);
    check("pixel faults", 0, n_bad);
    report_and_stop();
  end
endmodule : sensor_frame_timing_generator_test
